// File: rtl/hazard_map.vh
// Constant map for the pipeline hazard and latency control block
`ifndef HAZARD_MAP_VH
`define HAZARD_MAP_VH

// ----------------------------------------
// Operation codes presented with op_code
// ----------------------------------------
`define OP_MULT16 5'h00
`define OP_MULT32 5'h01
`define OP_MUL16 5'h02
`define OP_MUL32 5'h03
`define OP_DMULT 5'h04
`define OP_DIV 5'h05
`define OP_DDIV 5'h06
`define OP_FADD 5'h08
`define OP_FMUL 5'h09
`define OP_FMADD 5'h0A
`define OP_FDIV 5'h0B
`define OP_FSQRT 5'h0C
`define OP_FRECIP 5'h0D
`define OP_FRSQRT 5'h0E
`define OP_FCVT_SW 5'h0F
`define OP_FCVT 5'h10
`define OP_FSIMPLE 5'h11
`define OP_FMEM 5'h12

// ----------------------------------------
// Latency / repeat / stall figures (core cycles)
// ----------------------------------------
`define T_1 7'h01
`define T_2 7'h02
`define T_3 7'h03
`define T_4 7'h04
`define T_5 7'h05
`define T_6 7'h06
`define T_8 7'h08
`define T_9 7'h09
`define T_19 7'h13
`define T_21 7'h15
`define T_34 7'h22
`define T_36 7'h24
`define T_38 7'h26
`define T_66 7'h42
`define T_68 7'h44
`define T_0 7'h00

// ----------------------------------------
// System clock divisor and cache-op settle
// ----------------------------------------
`define DIV_MIN 4'h2
`define DIV_MAX 4'h8
`define QUIET_EXTRA 2'h3

// ----------------------------------------
// One-hot service grant bit positions
// ----------------------------------------
`define SRV_EXT 0
`define SRV_WB 1
`define SRV_IMISS 2
`define SRV_DMISS 3
`define SRV_COP 4

`endif

// File: rtl/op_timing_lut.v
// Latency, repeat and issue-stall lookup for multiply/divide and FPU ops
`timescale 1ns/1ps
`default_nettype none
`include "hazard_map.vh"

module op_timing_lut (
    input wire [4:0] op_code,
    input wire op_dbl,
    output reg [6:0] lat,
    output reg [6:0] rep,
    output reg [6:0] stl,
    output reg is_md
);

// ----------------------------------------
// Table decode
// ----------------------------------------
// Pure decode; the caller registers everything it keeps
always @* begin
    lat = `T_1;
    rep = `T_1;
    stl = `T_0;
    is_md = 1'b0;
    case (op_code)
        `OP_MULT16: begin lat = `T_4; rep = `T_3; is_md = 1'b1; end
        `OP_MULT32: begin lat = `T_5; rep = `T_4; is_md = 1'b1; end
        `OP_MUL16: begin
            lat = `T_4; rep = `T_2; stl = `T_1; is_md = 1'b1;
        end
        `OP_MUL32: begin
            lat = `T_5; rep = `T_3; stl = `T_2; is_md = 1'b1;
        end
        `OP_DMULT: begin lat = `T_9; rep = `T_8; is_md = 1'b1; end
        `OP_DIV: begin lat = `T_36; rep = `T_36; is_md = 1'b1; end
        `OP_DDIV: begin lat = `T_68; rep = `T_68; is_md = 1'b1; end
        `OP_FADD: begin lat = `T_4; rep = `T_1; end
        `OP_FMUL, `OP_FMADD: begin
            lat = op_dbl ? `T_5 : `T_4;
            rep = op_dbl ? `T_2 : `T_1;
        end
        `OP_FDIV, `OP_FSQRT, `OP_FRECIP: begin
            lat = op_dbl ? `T_36 : `T_21;
            rep = op_dbl ? `T_34 : `T_19;
        end
        `OP_FRSQRT: begin
            lat = op_dbl ? `T_68 : `T_38;
            rep = op_dbl ? `T_66 : `T_36;
        end
        `OP_FCVT_SW: begin lat = `T_6; rep = `T_3; end
        `OP_FCVT: begin lat = `T_4; rep = `T_1; end
        `OP_FSIMPLE: begin lat = `T_1; rep = `T_1; end
        `OP_FMEM: begin lat = `T_2; rep = `T_1; end
        default: begin lat = `T_1; rep = `T_1; end
    endcase
end

endmodule
`default_nettype wire

// File: rtl/sys_phase.v
// Core-to-system clock phase tracker with a clamped integer divisor
`timescale 1ns/1ps
`default_nettype none
`include "hazard_map.vh"

module sys_phase (
    input wire clk,
    input wire rst_b,
    input wire [3:0] sys_clock_divisor,
    output reg sys_edge_r
);

reg [3:0] cnt_r; // Core cycles since last system edge
reg [3:0] div_eff; // Divisor forced into the legal range

// ----------------------------------------
// Divisor clamp
// ----------------------------------------
// Out-of-range settings are clamped rather than trusted
always @* begin
    if (sys_clock_divisor < `DIV_MIN)
        div_eff = `DIV_MIN;
    else if (sys_clock_divisor > `DIV_MAX)
        div_eff = `DIV_MAX;
    else
        div_eff = sys_clock_divisor;
end

// ----------------------------------------
// Phase counter
// ----------------------------------------
// One system cycle spans div_eff core cycles
always @(posedge clk) begin
    if (!rst_b) begin
        cnt_r <= 4'h0;
        sys_edge_r <= 1'b0;
    end else if (cnt_r >= div_eff - 4'h1) begin
        cnt_r <= 4'h0;
        sys_edge_r <= 1'b1;
    end else begin
        cnt_r <= cnt_r + 4'h1;
        sys_edge_r <= 1'b0;
    end
end

endmodule
`default_nettype wire

// File: rtl/pipeline_hazard_latency_control.v
// Issue interlocks, op timing and memory-service arbitration for the core
//
// Operation
// - Multiply/divide result writes are not interlocked; md_wr is unused
// - Integer multiply/divide latency, repeat, stall table
// - FP add, multiply, simple ops timing
// - FP divide, root, memory ops timing
// - Core clock is divisor two..eight times bus
// - Bus services wait for system clock edge
// - Data miss after external and instruction miss
// - Writeback buffer drains before data miss
// - Instruction miss yields to writeback and external
// - Cache op waits for all other services
// - Cache op and data miss never overlap
// - Some cache ops wait buffers empty plus three
// - Cache op needing writeback buffer waits drain
`timescale 1ns/1ps
`default_nettype none
`include "hazard_map.vh"

module pipeline_hazard_latency_control (
    input wire clk,
    input wire rst_b,
    input wire [3:0] sys_clock_divisor,
    input wire op_valid,
    input wire [4:0] op_code,
    input wire op_dbl,
    input wire md_rd,
    input wire md_wr,
    input wire ext_req,
    input wire wb_pending,
    input wire imiss_req,
    input wire dmiss_req,
    input wire cop_req,
    input wire cop_quiet,
    input wire store_buf_busy,
    input wire resp_buf_busy,
    input wire svc_done,
    output reg md_issue_block_r,
    output reg md_result_block_r,
    output reg fp_issue_block_r,
    output reg fp_result_block_r,
    output reg [4:0] grant_r,
    output reg arb_busy_r
);

// ----------------------------------------
// Arbiter states
// ----------------------------------------
localparam [3:0] S_IDLE = 4'h1; // Looking for work
localparam [3:0] S_QUIET = 4'h2; // Cache op waits for store/response buffers
localparam [3:0] S_ALIGN = 4'h4; // Waiting for the system clock edge
localparam [3:0] S_BUSY = 4'h8; // Service owns the bus

// ----------------------------------------
// Declarations
// ----------------------------------------
wire [6:0] lut_lat; // Result latency of the presented op
wire [6:0] lut_rep; // Repeat rate of the presented op
wire [6:0] lut_stl; // Extra issue stall of the presented op
wire lut_md; // Op belongs to the multiply/divide unit
wire sys_edge; // Pulse on each system clock boundary

reg [6:0] md_lat_r; // Cycles until muldiv_result_pair is valid
reg [6:0] md_lat_nxt;
reg [6:0] md_rep_r; // Cycles until the next muldiv issue
reg [6:0] md_rep_nxt;
reg [6:0] md_stl_r; // Issue stall left by register-destination multiply
reg [6:0] md_stl_nxt;
reg [6:0] fp_lat_r; // Cycles until the FPU result is valid
reg [6:0] fp_lat_nxt;
reg [6:0] fp_rep_r; // Cycles until the next FPU issue
reg [6:0] fp_rep_nxt;
reg md_take; // Muldiv op accepted this cycle
reg fp_take; // FPU op accepted this cycle

reg [3:0] state_r; // Arbiter state, one-hot
reg [3:0] state_nxt;
reg [4:0] sel_r; // Service chosen, one-hot
reg [4:0] sel_nxt;
reg [4:0] pick; // Highest-priority pending service
reg [4:0] grant_nxt;
reg [1:0] settle_r; // Extra cycles after buffers empty
reg [1:0] settle_nxt;
reg dirty_r; // A buffer held data when the cache op arrived or while it waited
reg dirty_nxt;

// ----------------------------------------
// Helpers
// ----------------------------------------
// Count-down step that stops at zero
function [6:0] dec_sat;
    input [6:0] v;
    begin
        dec_sat = (v == `T_0) ? `T_0 : v - `T_1;
    end
endfunction

// Load value for a counter that blocks for n-1 cycles after issue
function [6:0] load_cnt;
    input [6:0] n;
    begin
        load_cnt = (n == `T_0) ? `T_0 : n - `T_1;
    end
endfunction

// ----------------------------------------
// Sub-blocks
// ----------------------------------------
op_timing_lut u_lut (
    .op_code(op_code),
    .op_dbl(op_dbl),
    .lat(lut_lat),
    .rep(lut_rep),
    .stl(lut_stl),
    .is_md(lut_md)
);

sys_phase u_phase (
    .clk(clk),
    .rst_b(rst_b),
    .sys_clock_divisor(sys_clock_divisor),
    .sys_edge_r(sys_edge)
);

// ----------------------------------------
// Issue acceptance
// ----------------------------------------
// Ops offered while the block flag is up are ignored; the
// stream must hold them, so only the registered flag counts
always @* begin
    md_take = op_valid && lut_md && !md_issue_block_r;
    fp_take = op_valid && !lut_md && !fp_issue_block_r;
end

// ----------------------------------------
// Multiply/divide counters
// ----------------------------------------
// md_wr is not used, so direct writes to the result pair do not stall
// behind a result still in flight; only md_result_block_r flags it
always @* begin
    md_lat_nxt = dec_sat(md_lat_r);
    md_rep_nxt = dec_sat(md_rep_r);
    md_stl_nxt = dec_sat(md_stl_r);
    if (md_take) begin
        md_lat_nxt = load_cnt(lut_lat);
        md_rep_nxt = load_cnt(lut_rep);
        md_stl_nxt = lut_stl;
    end
end

// ----------------------------------------
// FPU counters
// ----------------------------------------
// Only one FPU op is tracked; a newer op replaces the older
// latency, which is fine since issue is in order
always @* begin
    fp_lat_nxt = dec_sat(fp_lat_r);
    fp_rep_nxt = dec_sat(fp_rep_r);
    if (fp_take) begin
        fp_lat_nxt = load_cnt(lut_lat);
        fp_rep_nxt = load_cnt(lut_rep);
    end
end

// ----------------------------------------
// Issue-side registers
// ----------------------------------------
// Block flags are computed from next counts so each is a flop
always @(posedge clk) begin
    if (!rst_b) begin
        md_lat_r <= `T_0;
        md_rep_r <= `T_0;
        md_stl_r <= `T_0;
        fp_lat_r <= `T_0;
        fp_rep_r <= `T_0;
        md_issue_block_r <= 1'b0;
        md_result_block_r <= 1'b0;
        fp_issue_block_r <= 1'b0;
        fp_result_block_r <= 1'b0;
    end else begin
        md_lat_r <= md_lat_nxt;
        md_rep_r <= md_rep_nxt;
        md_stl_r <= md_stl_nxt;
        fp_lat_r <= fp_lat_nxt;
        fp_rep_r <= fp_rep_nxt;
        // Register-destination multiply also holds issue
        md_issue_block_r <= (md_rep_nxt != `T_0) ||
                            (md_stl_nxt != `T_0);
        // Covers both reads and writes of the result pair
        md_result_block_r <= (md_lat_nxt != `T_0);
        fp_issue_block_r <= (fp_rep_nxt != `T_0) ||
                            (md_stl_nxt != `T_0);
        fp_result_block_r <= (fp_lat_nxt != `T_0);
    end
end

// ----------------------------------------
// Service priority
// ----------------------------------------
// External, then writeback drain, then instruction miss, then
// data miss, then cache op; the single grant keeps data misses
// and cache ops apart, and a cache op that refills the writeback
// buffer makes the next one wait for the drain
always @* begin
    pick = 5'h00;
    if (ext_req)
        pick[`SRV_EXT] = 1'b1;
    else if (wb_pending)
        pick[`SRV_WB] = 1'b1;
    else if (imiss_req)
        pick[`SRV_IMISS] = 1'b1;
    else if (dmiss_req)
        pick[`SRV_DMISS] = 1'b1;
    else if (cop_req)
        pick[`SRV_COP] = 1'b1;
end

// ----------------------------------------
// Arbiter next state
// ----------------------------------------
// md_rd and md_wr are not used; the flags above ignore them
// and they need no arbiter action
always @* begin
    state_nxt = state_r;
    sel_nxt = sel_r;
    grant_nxt = grant_r;
    settle_nxt = settle_r;
    dirty_nxt = dirty_r;
    case (state_r)
        S_IDLE: begin
            if (pick != 5'h00) begin
                sel_nxt = pick;
                if (pick[`SRV_COP] && cop_quiet) begin
                    dirty_nxt = store_buf_busy || resp_buf_busy;
                    settle_nxt = 2'h0;
                    state_nxt = S_QUIET;
                end else begin
                    state_nxt = S_ALIGN;
                end
            end
        end
        S_QUIET: begin
            if (store_buf_busy || resp_buf_busy) begin
                dirty_nxt = 1'b1;
            end else if (!dirty_r || settle_r == `QUIET_EXTRA - 2'h1) begin
                state_nxt = S_ALIGN;
            end else begin
                settle_nxt = settle_r + 2'h1;
            end
        end
        S_ALIGN: begin
            // Waits 0..divisor-1 core cycles for the boundary
            if (sys_edge) begin
                grant_nxt = sel_r;
                state_nxt = S_BUSY;
            end
        end
        S_BUSY: begin
            if (svc_done) begin
                grant_nxt = 5'h00;
                sel_nxt = 5'h00;
                dirty_nxt = 1'b0;
                state_nxt = S_IDLE;
            end
        end
        default: begin
            grant_nxt = 5'h00;
            sel_nxt = 5'h00;
            state_nxt = S_IDLE;
        end
    endcase
end

// ----------------------------------------
// Arbiter registers
// ----------------------------------------
// A requester dropping its line after selection is not
// re-checked; the chosen service is still granted
always @(posedge clk) begin
    if (!rst_b) begin
        state_r <= S_IDLE;
        sel_r <= 5'h00;
        grant_r <= 5'h00;
        settle_r <= 2'h0;
        dirty_r <= 1'b0;
        arb_busy_r <= 1'b0;
    end else begin
        state_r <= state_nxt;
        sel_r <= sel_nxt;
        grant_r <= grant_nxt;
        settle_r <= settle_nxt;
        dirty_r <= dirty_nxt;
        arb_busy_r <= (state_nxt != S_IDLE);
    end
end

endmodule
`default_nettype wire

// File: verification/hazard_checker.sv
// Port checker for the issue interlocks and service grants
`timescale 1ns/1ps
`default_nettype none
`include "hazard_map.vh"
module hazard_checker (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic op_valid,
    input wire logic [4:0] op_code,
    input wire logic ext_req,
    input wire logic wb_pending,
    input wire logic imiss_req,
    input wire logic svc_done,
    input wire logic md_issue_block_r,
    input wire logic md_result_block_r,
    input wire logic fp_issue_block_r,
    input wire logic fp_result_block_r,
    input wire logic [4:0] grant_r,
    input wire logic arb_busy_r
);
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    wire md_go = op_valid && op_code <= `OP_DDIV && !md_issue_block_r; // Muldiv op accepted now
    wire fp_go = op_valid && !fp_issue_block_r; // FP op accepted now
    wire idle = !arb_busy_r && grant_r == 5'h00; // Arbiter is free to take a request now
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    AST_MD_LAT: assert property (
        md_go && op_code == `OP_MULT32 |=> md_result_block_r [*4] ##1
        (!md_result_block_r || $past(md_go)))
        else $error("mult32 result block span wrong");
    AST_MD_REP: assert property (
        md_go && op_code == `OP_MULT32 |=> md_issue_block_r [*3] ##1 !md_issue_block_r)
        else $error("mult32 repeat span wrong");
    AST_MUL_STALL: assert property (
        md_go && op_code == `OP_MUL32 |=> md_issue_block_r [*2] ##1 !md_issue_block_r)
        else $error("mul32 stall span wrong");
    AST_FADD_RATE: assert property (
        fp_go && op_code == `OP_FADD |=> !fp_issue_block_r && fp_result_block_r)
        else $error("fadd rate wrong");
    AST_FMEM_RATE: assert property (
        fp_go && op_code == `OP_FMEM |=> !fp_issue_block_r && fp_result_block_r)
        else $error("fp memory op rate wrong");
    AST_ONE_SVC: assert property ($onehot0(grant_r))
        else $error("two services granted");
    AST_GRANT_HOLD: assert property (
        (grant_r != 5'h00) && !svc_done |=> $stable(grant_r))
        else $error("grant changed before done");
    AST_GRANT_END: assert property (
        (grant_r != 5'h00) && svc_done |=> grant_r == 5'h00 && !arb_busy_r)
        else $error("grant not released after done");
    AST_EXT_FIRST: assert property (
        idle && ext_req |-> ##[2:9] grant_r == 5'h01)
        else $error("external request not granted first");
    AST_WB_FIRST: assert property (
        idle && !ext_req && wb_pending |-> ##[2:9] grant_r == 5'h02)
        else $error("writeback not granted first");
    AST_IMISS_FIRST: assert property (
        idle && !ext_req && !wb_pending && imiss_req |-> ##[2:9] grant_r == 5'h04)
        else $error("instruction miss not granted first");
endmodule
bind pipeline_hazard_latency_control hazard_checker u_hazard_checker (
    .clk(clk), .rst_b(rst_b), .op_valid(op_valid), .op_code(op_code),
    .ext_req(ext_req), .wb_pending(wb_pending), .imiss_req(imiss_req),
    .svc_done(svc_done), .md_issue_block_r(md_issue_block_r),
    .md_result_block_r(md_result_block_r), .fp_issue_block_r(fp_issue_block_r),
    .fp_result_block_r(fp_result_block_r), .grant_r(grant_r), .arb_busy_r(arb_busy_r)
);
`default_nettype wire

// File: verification/mem_agent.sv
// Behavioural system-bus agent that finishes each granted service
`timescale 1ns/1ps
`default_nettype none
module mem_agent (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [4:0] grant_r,
    input wire logic [2:0] svc_hold,
    output var logic svc_done
);
    logic [2:0] wait_r; // Cycles spent on the current service
    // ----------------------------------------
    // Service timer
    // ----------------------------------------
    // Variable hold lets both prompt and slow memory be seen
    always @(posedge clk) begin
        if (!rst_b) begin
            wait_r <= 3'h0;
            svc_done <= 1'b0;
        end else if (grant_r != 5'h00 && !svc_done) begin
            // One-cycle done pulse once the hold has run out
            svc_done <= (wait_r == svc_hold);
            wait_r <= (wait_r == svc_hold) ? 3'h0 : wait_r + 3'h1;
        end else begin
            svc_done <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// File: verification/testbench.sv
// Self-checking bench for the hazard and arbitration control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    // ----------------------------------------
    // Signals and model state
    // ----------------------------------------
    reg clk = 1'b0;
    reg rst_b = 1'b0;
    reg [3:0] sys_clock_divisor = 4'h2;
    reg op_valid = 1'b0;
    reg [4:0] op_code = 5'h00;
    reg op_dbl = 1'b0;
    reg [4:0] req_vec = 5'h00; // ext, wb, imiss, dmiss, cop
    reg cop_quiet = 1'b0;
    reg [1:0] buf_busy = 2'b00; // Store and response buffers
    reg [2:0] svc_hold = 3'h0;
    wire svc_done, md_issue_block_r, md_result_block_r, fp_issue_block_r, fp_result_block_r;
    wire arb_busy_r;
    wire [4:0] grant_r;
    integer md_res = 0, md_iss = 0, fp_res = 0, fp_iss = 0, stall_n = 0; // Model counters
    integer num_errors = 0, cmp_count = 0, cyc = 0, i;
    reg last_taken = 1'b0; // Model accepted the op at the last edge
    pipeline_hazard_latency_control u_pipeline_hazard_latency_control (
        .clk(clk), .rst_b(rst_b), .sys_clock_divisor(sys_clock_divisor),
        .op_valid(op_valid), .op_code(op_code), .op_dbl(op_dbl), .md_rd(1'b0), .md_wr(1'b0),
        .ext_req(req_vec[0]), .wb_pending(req_vec[1]), .imiss_req(req_vec[2]),
        .dmiss_req(req_vec[3]), .cop_req(req_vec[4]), .cop_quiet(cop_quiet),
        .store_buf_busy(buf_busy[0]), .resp_buf_busy(buf_busy[1]), .svc_done(svc_done),
        .md_issue_block_r(md_issue_block_r), .md_result_block_r(md_result_block_r),
        .fp_issue_block_r(fp_issue_block_r), .fp_result_block_r(fp_result_block_r),
        .grant_r(grant_r), .arb_busy_r(arb_busy_r));
    mem_agent u_mem_agent (.clk(clk), .rst_b(rst_b), .grant_r(grant_r),
        .svc_hold(svc_hold), .svc_done(svc_done));
    always #12.5 clk = ~clk;
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // Latency, repeat and stall as {lat, rep, stall}
    function [20:0] timing(input [4:0] c, input d);
        case (c)
            5'h00: timing = {7'h04, 7'h03, 7'h00};
            5'h01: timing = {7'h05, 7'h04, 7'h00};
            5'h02: timing = {7'h04, 7'h02, 7'h01};
            5'h03: timing = {7'h05, 7'h03, 7'h02};
            5'h04: timing = {7'h09, 7'h08, 7'h00};
            5'h05: timing = {7'h24, 7'h24, 7'h00};
            5'h06: timing = {7'h44, 7'h44, 7'h00};
            5'h09, 5'h0A: timing = d ? {7'h05, 7'h02, 7'h00} : {7'h04, 7'h01, 7'h00};
            5'h0B, 5'h0C, 5'h0D: timing = d ? {7'h24, 7'h22, 7'h00} : {7'h15, 7'h13, 7'h00};
            5'h0E: timing = d ? {7'h44, 7'h42, 7'h00} : {7'h26, 7'h24, 7'h00};
            5'h0F: timing = {7'h06, 7'h03, 7'h00};
            5'h11: timing = {7'h01, 7'h01, 7'h00};
            5'h12: timing = {7'h02, 7'h01, 7'h00};
            default: timing = {7'h04, 7'h01, 7'h00}; // Add, subtract, other converts
        endcase
    endfunction
    task check(input string what, input [6:0] seen, input [6:0] exp);
        cmp_count = cmp_count + 1;
        if (seen !== exp) begin
            $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
            num_errors = num_errors + 1;
        end
    endtask
    // Inputs always change the same small delay after the edge
    task tick;
        @(posedge clk);
        #2;
    endtask
    task test_done;
        $display("Comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // ----------------------------------------
    // Reference model of the issue interlocks
    // ----------------------------------------
    always @(posedge clk) begin : model
        reg [20:0] t;
        reg md_ok, fp_ok;
        t = timing(op_code, op_dbl);
        md_ok = op_valid && op_code < 5'h08 && md_iss == 0;
        fp_ok = op_valid && op_code >= 5'h08 && fp_iss == 0 && stall_n == 0;
        md_res = (md_res > 0) ? md_res - 1 : 0;
        md_iss = (md_iss > 0) ? md_iss - 1 : 0;
        fp_res = (fp_res > 0) ? fp_res - 1 : 0;
        fp_iss = (fp_iss > 0) ? fp_iss - 1 : 0;
        stall_n = (stall_n > 0) ? stall_n - 1 : 0;
        last_taken = rst_b && (md_ok || fp_ok);
        if (!rst_b) begin
            md_res = 0; md_iss = 0; fp_res = 0; fp_iss = 0; stall_n = 0;
        end else if (md_ok) begin
            // Result pair stays locked until its latency has run
            md_res = t[20:14] - 1;
            md_iss = (t[13:7] - 1 > t[6:0]) ? t[13:7] - 1 : t[6:0];
            stall_n = t[6:0];
        end else if (fp_ok) begin
            fp_res = t[20:14] - 1;
            fp_iss = t[13:7] - 1;
        end
    end
    // Every cycle's flags outside reset are compared where they have settled
    always @(negedge clk) begin
        if (rst_b) begin
            check("md_result_block", md_result_block_r, md_res > 0);
            check("md_issue_block", md_issue_block_r, md_iss > 0);
            check("fp_result_block", fp_result_block_r, fp_res > 0);
            check("fp_issue_block", fp_issue_block_r, fp_iss > 0 || stall_n > 0);
        end
    end
    // Hang guard sized well above the expected run
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 30000) begin
            num_errors = num_errors + 1;
            test_done;
        end
    end
    // ----------------------------------------
    // One service: request set r, check winner and wait
    // ----------------------------------------
    task serve(input [4:0] r, input q, input [1:0] bz);
        integer n, lo, dv;
        reg [4:0] exp;
        exp = r & (~r + 5'h01); // Lowest bit has top priority
        sys_clock_divisor = $urandom % 16; // Out-of-range values exercise the clamp
        svc_hold = $urandom % 8;
        tick;
        tick;
        req_vec = r;
        cop_quiet = q;
        buf_busy = bz;
        for (n = 0; n < 80 && grant_r == 5'h00; n = n + 1) begin
            if (n == 5) buf_busy = 2'b00;
            tick;
        end
        lo = (q && exp[4]) ? 8 : 2;
        check("grant", grant_r, exp);
        dv = (sys_clock_divisor < 2) ? 2 : (sys_clock_divisor > 8) ? 8 : sys_clock_divisor;
        check("grant_wait", n >= lo && n <= lo + dv, 1'b1);
        req_vec = 5'h00;
        cop_quiet = 1'b0;
        for (n = 0; n < 20 && grant_r != 5'h00; n = n + 1) tick;
        tick;
        check("arb_busy", arb_busy_r, 1'b0);
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin : main
        reg [4:0] c;
        integer n, d;
        void'($urandom(32'hB1F5));
        repeat (6) tick;
        rst_b = 1'b1;
        // Every op code in both precisions from a quiet pipeline
        for (i = 0; i < 19; i = i + 1) begin
            for (d = 0; d < 2; d = d + 1) begin
                for (n = 0; n < 80 && (md_issue_block_r | md_result_block_r |
                    fp_issue_block_r | fp_result_block_r); n = n + 1) tick;
                op_valid = (i != 7);
                op_code = i;
                op_dbl = d;
                tick;
                op_valid = 1'b0;
                tick;
            end
        end
        $display("Test op_sweep done");
        // Random back-to-back ops, refused ops held, reset in mid-run
        for (i = 0; i < 1500; i = i + 1) begin
            rst_b = !(i == 700 || i == 701);
            if (!op_valid || last_taken) begin
                c = $urandom % 19;
                op_valid = $urandom % 2;
                // Timed ops only: no translation, return, lock or delay-slot sequences
                op_code = (c == 5'h07) ? 5'h08 : c;
                op_dbl = $urandom % 2;
            end
            tick;
        end
        op_valid = 1'b0;
        $display("Test op_random done");
        // Every combination of pending requests
        for (i = 1; i < 32; i = i + 1) serve(i, 1'b0, $urandom % 4);
        $display("Test priority done");
        // Cache ops waiting for busy buffers, then behind other traffic
        serve(5'h10, 1'b1, 2'b01);
        serve(5'h10, 1'b1, 2'b10);
        serve(5'h18, 1'b1, 2'b11);
        serve(5'h12, 1'b1, 2'b01);
        $display("Test cache_op done");
        test_done;
    end
endmodule
`default_nettype wire
